// ==== mph_pkg.sv ====
// Package of constants and carrier types for the modem parallel host port
// Summary of operation
// - Internal decode: port-select pins choose 3F8, 2F8, 3E8 or 2E8 ranges.
// - Interface type 10: chip-select pin is an input, low enables access.
// - Interface types 01 and 11: chip-select pin is driven as output.
// - Output role: acknowledge low while access addresses device, high otherwise.
// - Addressed access with write strobe low writes data byte to selected register.
// - Enabled interrupt output goes high on enabled pending interrupt condition.
// - Four interrupt sources, each enabled by a bit of irq_enable_reg.
// - Transmit-empty interrupt clears on an IIR read that names it; other sources follow the UART core event inputs.
// - Disabled interrupt output is high impedance, never driven low.
// - Plug-and-play: seven interrupt pins, only selected one driven, others released.
// - Other modes: all seven interrupt pins asserted together.
// - Eight-bit data bus driven only during qualified read, sampled on write.
// - Addressed access with read strobe low drives selected register onto bus.
// - Three lowest address lines select one of eight registers.
// - Interface-select pins sampled only during reset, latched afterwards.
// - Open-drain ready output inserts wait states until access can complete.
package mph_pkg;
  // ------------------------------------------------------------
  // Interface types
  // ------------------------------------------------------------
  localparam logic [1:0] MPH_IF_SERIAL = 2'h0;
  localparam logic [1:0] MPH_IF_PNP = 2'h1;
  localparam logic [1:0] MPH_IF_EXT = 2'h2;
  localparam logic [1:0] MPH_IF_INT = 2'h3;
  // ------------------------------------------------------------
  // Port ranges, address bits 9:3
  // ------------------------------------------------------------
  localparam logic [6:0] MPH_BASE_COM1 = 7'h7f;
  localparam logic [6:0] MPH_BASE_COM2 = 7'h5f;
  localparam logic [6:0] MPH_BASE_COM3 = 7'h7d;
  localparam logic [6:0] MPH_BASE_COM4 = 7'h5d;
  // ------------------------------------------------------------
  // Register offsets and fields
  // ------------------------------------------------------------
  localparam logic [2:0] MPH_REG_DATA = 3'h0;
  localparam logic [2:0] MPH_REG_IRQ_EN = 3'h1;
  localparam logic [2:0] MPH_REG_IIR = 3'h2;
  localparam logic [2:0] MPH_REG_LSR = 3'h5;
  localparam logic [2:0] MPH_REG_MSR = 3'h6;
  localparam int MPH_IEN_RDA = 0;
  localparam int MPH_IEN_THRE = 1;
  localparam int MPH_IEN_RLS = 2;
  localparam int MPH_IEN_MS = 3;
  localparam logic [3:0] MPH_IIR_NONE = 4'h1;
  localparam logic [3:0] MPH_IIR_RLS = 4'h6;
  localparam logic [3:0] MPH_IIR_RDA = 4'h4;
  localparam logic [3:0] MPH_IIR_THRE = 4'h2;
  localparam logic [3:0] MPH_IIR_MS = 4'h0;
  localparam logic [7:0] MPH_REG_RST = 8'h00;
  localparam int MPH_IRQ_PINS = 7;
  localparam int MPH_WAIT_CYC = 2;

  typedef enum logic [1:0] {
    MPH_ST_IDLE,
    MPH_ST_WAIT,
    MPH_ST_DONE
  } mph_state_t;

  // Host bus pins after synchronisation
  typedef struct packed {
    logic [9:0] addr;
    logic aen_n;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic [7:0] data;
  } mph_host_t;

  // Events from the UART core
  typedef struct packed {
    logic rx_avail;
    logic line_stat;
    logic modem_stat;
  } mph_uart_ev_t;
endpackage

// ==== mph_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module mph_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  if (W < 1) begin : g_bad_width
    $error("W must be at least one");
  end
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mph_sync_st_t;
  mph_sync_st_t st_r;
  mph_sync_st_t st_nxt;

  always_comb begin
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule
`default_nettype wire

// ==== mph_host_port.sv ====
// Parallel host port: decode, register access, interrupt pins
`timescale 1ns/1ps
`default_nettype none
module mph_host_port #(
  parameter int WAIT_CYC = mph_pkg::MPH_WAIT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Interface straps and port select
  input wire logic iface_type_sel_lo_i,
  input wire logic iface_type_sel_hi_i,
  input wire logic port_select_lo_i,
  input wire logic port_select_hi_i,
  // Host bus
  input wire logic [9:0] host_addr_bus_i,
  input wire logic host_aen_n_i,
  input wire logic host_read_n_i,
  input wire logic host_write_n_i,
  input wire logic host_chip_sel_n_i,
  output logic chip_ack_n_o,
  output logic chip_ack_oe_o,
  input wire logic [7:0] host_data_bus_i,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  output logic host_ready_oe_o,
  // Interrupt pins
  input wire logic host_irq_out_en_i,
  input wire logic [2:0] host_irq_pin_sel_i,
  output logic [mph_pkg::MPH_IRQ_PINS-1:0] host_irq_lines_o,
  output logic [mph_pkg::MPH_IRQ_PINS-1:0] host_irq_lines_oe_o,
  // UART core side
  input wire mph_pkg::mph_uart_ev_t uart_ev_i,
  input wire logic [7:0] uart_rx_data_i,
  input wire logic [7:0] uart_lsr_i,
  input wire logic [7:0] uart_msr_i,
  output logic uart_wr_o,
  output logic [2:0] uart_wr_addr_o,
  output logic [7:0] uart_wr_data_o,
  output logic [1:0] iface_type_o
);
  import mph_pkg::*;

  // Wait counter is four bits wide
  if (WAIT_CYC < 1 || WAIT_CYC > 15) begin : g_bad_wait
    $error("WAIT_CYC out of range");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  mph_host_t hs;
  logic [3:0] straps;
  mph_sync #(.W($bits(mph_host_t))) u_sync_host (
    .clk_i(clk_i),
    .rst_i(1'b0),
    .d_i({host_addr_bus_i, host_aen_n_i, host_read_n_i, host_write_n_i, host_chip_sel_n_i, host_data_bus_i}),
    .q_o(hs)
  );
  mph_sync #(.W(4)) u_sync_strap (
    .clk_i(clk_i),
    .rst_i(1'b0),
    .d_i({iface_type_sel_hi_i, iface_type_sel_lo_i, port_select_hi_i, port_select_lo_i}),
    .q_o(straps)
  );

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    mph_state_t st;
    logic [3:0] wcnt;
    logic [1:0] itype;
    logic [7:0] ien;
    logic thre_pend;
    logic rd_cycle;
    logic ack_n;
    logic ack_oe;
    logic [7:0] dout;
    logic dout_oe;
    logic rdy_oe;
    logic [MPH_IRQ_PINS-1:0] irq;
    logic [MPH_IRQ_PINS-1:0] irq_oe;
    logic wr;
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
  } mph_st_t;
  mph_st_t r_r;
  mph_st_t r_nxt;

  logic [6:0] base;
  logic hit;
  logic strobe;
  logic [3:0] pend;
  logic [3:0] iir_id;
  logic [7:0] rd_val;

  always_comb begin
    unique case ({straps[1], straps[0]})
      2'b00: base = MPH_BASE_COM1;
      2'b01: base = MPH_BASE_COM2;
      2'b10: base = MPH_BASE_COM3;
      2'b11: base = MPH_BASE_COM4;
    endcase
    if (r_r.itype == MPH_IF_EXT) begin
      hit = !hs.cs_n;
    end else if (r_r.itype == MPH_IF_INT || r_r.itype == MPH_IF_PNP) begin
      hit = !hs.aen_n && (hs.addr[9:3] == base);
    end else begin
      hit = 1'b0;
    end
    strobe = hit && (!hs.rd_n || !hs.wr_n);
    // Priority: line status, rx data, tx empty, modem status
    pend[MPH_IEN_RLS] = r_r.ien[MPH_IEN_RLS] && uart_ev_i.line_stat;
    pend[MPH_IEN_RDA] = r_r.ien[MPH_IEN_RDA] && uart_ev_i.rx_avail;
    pend[MPH_IEN_THRE] = r_r.ien[MPH_IEN_THRE] && r_r.thre_pend;
    pend[MPH_IEN_MS] = r_r.ien[MPH_IEN_MS] && uart_ev_i.modem_stat;
    if (pend[MPH_IEN_RLS]) begin
      iir_id = MPH_IIR_RLS;
    end else if (pend[MPH_IEN_RDA]) begin
      iir_id = MPH_IIR_RDA;
    end else if (pend[MPH_IEN_THRE]) begin
      iir_id = MPH_IIR_THRE;
    end else if (pend[MPH_IEN_MS]) begin
      iir_id = MPH_IIR_MS;
    end else begin
      iir_id = MPH_IIR_NONE;
    end
    unique case (hs.addr[2:0])
      MPH_REG_DATA: rd_val = uart_rx_data_i;
      MPH_REG_IRQ_EN: rd_val = r_r.ien;
      MPH_REG_IIR: rd_val = {4'h0, iir_id};
      MPH_REG_LSR: rd_val = uart_lsr_i;
      MPH_REG_MSR: rd_val = uart_msr_i;
      default: rd_val = MPH_REG_RST;
    endcase

    r_nxt = r_r;
    r_nxt.wr = 1'b0;
    // Strap latch while reset held is done in the always_ff
    r_nxt.ack_oe = (r_r.itype == MPH_IF_PNP) || (r_r.itype == MPH_IF_INT);
    r_nxt.ack_n = !(hit && r_nxt.ack_oe);
    unique case (r_r.st)
      MPH_ST_IDLE: begin
        r_nxt.dout_oe = 1'b0;
        r_nxt.rdy_oe = 1'b0;
        if (strobe) begin
          r_nxt.st = MPH_ST_WAIT;
          r_nxt.wcnt = 4'(WAIT_CYC);
          r_nxt.rdy_oe = 1'b1;
          r_nxt.rd_cycle = !hs.rd_n;
        end
      end
      MPH_ST_WAIT: begin
        if (r_r.wcnt > 4'h1) begin
          r_nxt.wcnt = r_r.wcnt - 4'h1;
        end else begin
          r_nxt.st = MPH_ST_DONE;
          r_nxt.rdy_oe = 1'b0;
          if (r_r.rd_cycle) begin
            r_nxt.dout = rd_val;
            r_nxt.dout_oe = 1'b1;
            if (hs.addr[2:0] == MPH_REG_IIR && iir_id == MPH_IIR_THRE) begin
              r_nxt.thre_pend = 1'b0;
            end
          end else begin
            r_nxt.wr = 1'b1;
            r_nxt.wr_addr = hs.addr[2:0];
            r_nxt.wr_data = hs.data;
            if (hs.addr[2:0] == MPH_REG_IRQ_EN) begin
              r_nxt.ien = {4'h0, hs.data[3:0]};
            end
            if (hs.addr[2:0] == MPH_REG_DATA) begin
              r_nxt.thre_pend = 1'b0;
            end
          end
        end
      end
      MPH_ST_DONE: begin
        if (!strobe) begin
          r_nxt.st = MPH_ST_IDLE;
          r_nxt.dout_oe = 1'b0;
          if (!r_r.rd_cycle && r_r.wr_addr == MPH_REG_DATA) begin
            r_nxt.thre_pend = 1'b1;
          end
        end
      end
      default: r_nxt.st = MPH_ST_IDLE;
    endcase
    // Interrupt pins
    for (int i = 0; i < MPH_IRQ_PINS; i++) begin
      if (!host_irq_out_en_i) begin
        r_nxt.irq_oe[i] = 1'b0;
      end else if (r_r.itype == MPH_IF_PNP) begin
        r_nxt.irq_oe[i] = (3'(i) == host_irq_pin_sel_i);
      end else begin
        r_nxt.irq_oe[i] = 1'b1;
      end
      r_nxt.irq[i] = r_nxt.irq_oe[i] && (|pend);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_r.st <= MPH_ST_IDLE;
      r_r.wcnt <= '0;
      r_r.itype <= straps[3:2];
      r_r.ien <= MPH_REG_RST;
      r_r.thre_pend <= 1'b1;
      r_r.rd_cycle <= 1'b0;
      r_r.ack_n <= 1'b1;
      r_r.ack_oe <= 1'b0;
      r_r.dout <= MPH_REG_RST;
      r_r.dout_oe <= 1'b0;
      r_r.rdy_oe <= 1'b0;
      r_r.irq <= '0;
      r_r.irq_oe <= '0;
      r_r.wr <= 1'b0;
      r_r.wr_addr <= '0;
      r_r.wr_data <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign chip_ack_n_o = r_r.ack_n;
  assign chip_ack_oe_o = r_r.ack_oe;
  assign host_data_bus_o = r_r.dout;
  assign host_data_bus_oe_o = r_r.dout_oe;
  assign host_ready_oe_o = r_r.rdy_oe;
  assign host_irq_lines_o = r_r.irq;
  assign host_irq_lines_oe_o = r_r.irq_oe;
  assign uart_wr_o = r_r.wr;
  assign uart_wr_addr_o = r_r.wr_addr;
  assign uart_wr_data_o = r_r.wr_data;
  assign iface_type_o = r_r.itype;
endmodule
`default_nettype wire

// ==== mph_host_port_monitor.sv ====
// Checker bound to the parallel host port
`timescale 1ns/1ps
`default_nettype none
module mph_host_port_monitor #(
  parameter int WAIT_CYC = mph_pkg::MPH_WAIT_CYC
) (
  // Clock, reset, host pins
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [9:0] host_addr_bus_i,
  input wire logic host_aen_n_i,
  input wire logic host_write_n_i,
  input wire logic [7:0] host_data_bus_i,
  input wire logic host_irq_out_en_i,
  // Design outputs
  input wire logic chip_ack_n_o,
  input wire logic chip_ack_oe_o,
  input wire logic host_data_bus_oe_o,
  input wire logic host_ready_oe_o,
  input wire logic [mph_pkg::MPH_IRQ_PINS-1:0] host_irq_lines_o,
  input wire logic [mph_pkg::MPH_IRQ_PINS-1:0] host_irq_lines_oe_o,
  input wire logic uart_wr_o,
  input wire logic [2:0] uart_wr_addr_o,
  input wire logic [7:0] uart_wr_data_o,
  input wire logic [1:0] iface_type_o
);
  import mph_pkg::*;
  logic [2:0] a_lo;
  logic [3:0] rdy_cnt;
  assign a_lo = host_addr_bus_i[2:0];
  // Counts wait-state cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || !host_ready_oe_o) rdy_cnt <= 4'h0;
    else rdy_cnt <= rdy_cnt + 4'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_pulse; uart_wr_o ##1 !uart_wr_o; endsequence
  sequence s_quiet; !host_irq_out_en_i [*4]; endsequence
  property p_role; !$past(rst_i) |-> chip_ack_oe_o == iface_type_o[0]; endproperty
  property p_ack; $fell(chip_ack_n_o) |-> !$past(host_aen_n_i, 2); endproperty
  property p_pulse; $rose(uart_wr_o) |-> s_pulse; endproperty
  property p_sel; uart_wr_o |-> uart_wr_addr_o == $past(a_lo) && uart_wr_data_o == $past(host_data_bus_i);
  endproperty
  property p_dir; host_data_bus_oe_o |-> host_write_n_i; endproperty
  property p_wait; $rose(host_data_bus_oe_o) || $rose(uart_wr_o) |-> $past(host_ready_oe_o); endproperty
  property p_wlen; $fell(host_ready_oe_o) |-> rdy_cnt == 4'(WAIT_CYC); endproperty
  property p_off; s_quiet |-> host_irq_lines_oe_o == 7'h00; endproperty
  property p_one; iface_type_o == MPH_IF_PNP |-> $onehot0(host_irq_lines_oe_o); endproperty
  property p_all; iface_type_o != MPH_IF_PNP |-> host_irq_lines_oe_o inside {7'h00, 7'h7f}; endproperty
  property p_lvl; iface_type_o != MPH_IF_PNP |-> host_irq_lines_o inside {7'h00, 7'h7f}; endproperty
  a_role: assert property (p_role) else $error("ack role wrong");
  a_ack: assert property (p_ack) else $error("ack without access");
  a_pulse: assert property (p_pulse) else $error("write pulse long");
  a_sel: assert property (p_sel) else $error("write reg or data wrong");
  a_dir: assert property (p_dir) else $error("bus driven in write");
  a_wait: assert property (p_wait) else $error("no wait state");
  a_wlen: assert property (p_wlen) else $error("wait length wrong");
  a_off: assert property (p_off) else $error("disabled irq driven");
  a_one: assert property (p_one) else $error("several irq pins");
  a_all: assert property (p_all) else $error("irq pins split");
  a_lvl: assert property (p_lvl) else $error("irq levels split");
endmodule
bind mph_host_port mph_host_port_monitor #(.WAIT_CYC(WAIT_CYC)) u_mon (.clk_i, .rst_i,
  .host_addr_bus_i, .host_aen_n_i, .host_write_n_i, .host_data_bus_i, .host_irq_out_en_i,
  .chip_ack_n_o, .chip_ack_oe_o, .host_data_bus_oe_o, .host_ready_oe_o, .host_irq_lines_o,
  .host_irq_lines_oe_o, .uart_wr_o, .uart_wr_addr_o, .uart_wr_data_o, .iface_type_o);
`default_nettype wire

// ==== mph_host_model.sv ====
// Host bus master model
`timescale 1ns/1ps
`default_nettype none
module mph_host_model (
  // Clock and answers
  input wire logic clk_i,
  input wire logic data_oe_i,
  input wire logic [7:0] data_i,
  input wire logic wr_done_i,
  // Host bus
  output logic [9:0] addr_o = 10'h000,
  output logic aen_n_o = 1'b1,
  output logic rd_n_o = 1'b1,
  output logic wr_n_o = 1'b1,
  output logic cs_n_o = 1'b1,
  output logic [7:0] data_o = 8'h00
);
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d, input logic cs,
                     output logic ok, output logic [7:0] q);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge clk_i);
    addr_o <= a;
    aen_n_o <= 1'b0;
    cs_n_o <= cs;
    data_o <= w ? d : ~data_o;
    rd_n_o <= w;
    wr_n_o <= !w;
    while (!ok && n < 16) begin
      @(posedge clk_i);
      n++;
      ok = w ? wr_done_i : data_oe_i;
    end
    q = data_i;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    aen_n_o <= 1'b1;
    cs_n_o <= 1'b1;
    data_o <= ~d;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Testbench for the parallel host port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mph_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] strap = 2'h3;
  logic [1:0] psel = 2'h0;
  logic irq_en = 1'b0;
  logic [2:0] pin_sel = 3'h0;
  mph_uart_ev_t ev = '0;
  logic [9:0] addr;
  logic aen_n, rd_n, wr_n, cs_n, doe, ack_n, ack_oe, uwr, ok, rdy;
  logic [2:0] waddr;
  logic [7:0] wdata;
  int ack_lows = 0;
  int rdy_cyc = 0;
  logic [7:0] hdi, hdo, q;
  logic [6:0] irq, irq_oe;
  logic [1:0] itype;
  int n_fail = 0;
  int samples_checked = 0;
  logic [9:0] base [4] = '{10'h3f8, 10'h2f8, 10'h3e8, 10'h2e8};
  always #4 clk_i = ~clk_i;
  // Counts cycles with acknowledge low and with a wait state
  always @(posedge clk_i) begin
    if (ack_n === 1'b0) begin
      ack_lows <= ack_lows + 1;
    end
    if (rdy === 1'b1) begin
      rdy_cyc <= rdy_cyc + 1;
    end
  end
  mph_host_port dut (.clk_i, .rst_i, .iface_type_sel_lo_i(strap[0]), .iface_type_sel_hi_i(strap[1]),
    .port_select_lo_i(psel[0]), .port_select_hi_i(psel[1]), .host_addr_bus_i(addr),
    .host_aen_n_i(aen_n), .host_read_n_i(rd_n), .host_write_n_i(wr_n), .host_chip_sel_n_i(cs_n),
    .chip_ack_n_o(ack_n), .chip_ack_oe_o(ack_oe), .host_data_bus_i(hdi), .host_data_bus_o(hdo),
    .host_data_bus_oe_o(doe), .host_ready_oe_o(rdy), .host_irq_out_en_i(irq_en),
    .host_irq_pin_sel_i(pin_sel), .host_irq_lines_o(irq), .host_irq_lines_oe_o(irq_oe),
    .uart_ev_i(ev), .uart_rx_data_i(8'h96), .uart_lsr_i(8'ha5), .uart_msr_i(8'h3c),
    .uart_wr_o(uwr), .uart_wr_addr_o(waddr), .uart_wr_data_o(wdata), .iface_type_o(itype));
  mph_host_model host (.clk_i, .data_oe_i(doe), .data_i(hdo), .wr_done_i(uwr), .addr_o(addr),
    .aen_n_o(aen_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .cs_n_o(cs_n), .data_o(hdi));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rst(input logic [1:0] st, input logic [1:0] p);
    @(posedge clk_i);
    strap <= st;
    psel <= p;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    strap <= ~st;
    repeat (3) @(posedge clk_i);
    chk("type", {6'h00, st}, {6'h00, itype});
  endtask
  task automatic t_decode();
    int c;
    for (int k = 0; k < 4; k++) begin
      rst(2'h3, 2'(k));
      chk("ack oe", 8'h01, {7'h00, ack_oe});
      c = ack_lows;
      host.acc(1'b1, base[k] + 10'h007, 8'h5a, 1'b1, ok, q);
      chk("hit", 8'h01, {7'h00, ok});
      chk("ack", 8'h01, {7'h00, ack_lows != c});
      chk("waddr", 8'h07, {5'h00, waddr});
      chk("wdata", 8'h5a, wdata);
      c = ack_lows;
      host.acc(1'b1, base[3 - k] + 10'h007, 8'h5a, 1'b1, ok, q);
      chk("miss", 8'h00, {7'h00, ok});
      chk("no ack", 8'h00, {7'h00, ack_lows != c});
    end
  endtask
  task automatic t_read();
    logic [2:0] offs [3] = '{3'h0, 3'h5, 3'h6};
    logic [7:0] vals [3] = '{8'h96, 8'ha5, 8'h3c};
    int c;
    rst(2'h3, 2'h0);
    for (int i = 0; i < 3; i++) begin
      c = rdy_cyc;
      host.acc(1'b0, 10'h3f8 + 10'(offs[i]), 8'h00, 1'b1, ok, q);
      chk("rdata", vals[i], q);
      chk("wait", 8'(MPH_WAIT_CYC), 8'(rdy_cyc - c));
    end
  endtask
  task automatic t_irq();
    mph_uart_ev_t evs [4] = '{3'b100, 3'b000, 3'b010, 3'b001};
    logic [3:0] ids [4] = '{MPH_IIR_RDA, MPH_IIR_THRE, MPH_IIR_RLS, MPH_IIR_MS};
    irq_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.acc(1'b1, 10'h3f9, 8'(1 << i), 1'b1, ok, q);
      ev <= evs[i];
      repeat (6) @(posedge clk_i);
      chk("irq on", 8'h7f, {1'b0, irq});
      chk("irq oe", 8'h7f, {1'b0, irq_oe});
      host.acc(1'b0, 10'h3fa, 8'h00, 1'b1, ok, q);
      chk("irq id", {4'h0, ids[i]}, q);
      ev <= '0;
      repeat (6) @(posedge clk_i);
      chk("irq off", 8'h00, {1'b0, irq});
    end
    // Transmit empty stays cleared until a data write completes
    host.acc(1'b1, 10'h3f9, 8'h02, 1'b1, ok, q);
    repeat (6) @(posedge clk_i);
    chk("thre clear", 8'h00, {1'b0, irq});
    host.acc(1'b1, 10'h3f8, 8'h77, 1'b1, ok, q);
    repeat (6) @(posedge clk_i);
    chk("thre again", 8'h7f, {1'b0, irq});
    ev <= 3'b100;
    irq_en <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("irq hiz", 8'h00, {1'b0, irq_oe});
    rst(2'h1, 2'h0);
    pin_sel <= 3'h3;
    irq_en <= 1'b1;
    host.acc(1'b1, 10'h3f9, 8'h01, 1'b1, ok, q);
    repeat (6) @(posedge clk_i);
    chk("pnp oe", 8'h08, {1'b0, irq_oe});
    chk("pnp irq", 8'h08, {1'b0, irq});
    ev <= '0;
  endtask
  task automatic t_ext();
    rst(2'h2, 2'h0);
    chk("ext ack oe", 8'h00, {7'h00, ack_oe});
    host.acc(1'b1, 10'h3f8, 8'h11, 1'b1, ok, q);
    chk("cs off", 8'h00, {7'h00, ok});
    host.acc(1'b1, 10'h123, 8'h11, 1'b0, ok, q);
    chk("cs on", 8'h01, {7'h00, ok});
    rst(2'h0, 2'h0);
    host.acc(1'b1, 10'h3f8, 8'h11, 1'b0, ok, q);
    chk("serial", 8'h00, {7'h00, ok});
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    t_decode();
    t_read();
    t_irq();
    t_ext();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
